// file: rtl/iedsel_pkg.sv
// Package: register map, channel layout and field positions for the block
package iedsel_pkg;
    localparam int          IEDSEL_CHANNELS      = 16;
    localparam int          IEDSEL_ADDR_W        = 16;
    localparam logic [15:0] IEDSEL_DMA_LO_ADDR   = 16'hffe8;
    localparam logic [15:0] IEDSEL_DMA_HI_ADDR   = 16'hffe9;
    localparam logic [15:0] IEDSEL_REQ_LO_ADDR   = 16'hffea;
    localparam logic [15:0] IEDSEL_REQ_HI_ADDR   = 16'hffeb;
    localparam logic [15:0] IEDSEL_EXT_TRIG_ADDR = 16'hffe7;
    localparam logic [15:0] IEDSEL_IEN_LO_ADDR   = 16'hfff6;
    localparam logic [15:0] IEDSEL_IEN_HI_ADDR   = 16'hfff7;
    localparam logic [7:0]  IEDSEL_RESET_BYTE    = 8'h00;
    localparam int          IEDSEL_EDGE_BIT      = 6;
    localparam int          IEDSEL_EXT0_CH       = 3;
    localparam int          IEDSEL_RX_CH         = 12;
    localparam int          IEDSEL_CH_IDX_W      = 5;
    localparam logic [7:0]  IEDSEL_EXT_TRIG_MASK = 8'h40;

    typedef enum logic [0:0] {
        IEDSEL_LEVEL = 1'b0,
        IEDSEL_EDGE  = 1'b1
    } iedsel_trig_t;
endpackage : iedsel_pkg

// file: rtl/iedsel_req_latch.sv
// One request latch with optional level bypass
`timescale 1ns/1ns
module iedsel_req_latch
    import iedsel_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic set_req,
    input  wire logic clr_req,
    input  wire logic bypass,
    input  wire logic level_in,
    output logic      pending
);
    logic latch_q;

    // Set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= 1'b0;
        end else if (set_req) begin
            latch_q <= 1'b1;
        end else if (clr_req) begin
            latch_q <= 1'b0;
        end
    end

    assign pending = bypass ? level_in : latch_q;
endmodule : iedsel_req_latch

// file: rtl/iedsel_ctrl.sv
// Interrupt enable, request latches and DMA select for all channels
//
// Overview of operation
// - One enable bit per channel in two bytes; channel enabled only when 1.
// - Reset clears every interrupt enable bit.
// - One DMA select bit per channel; 1 routes requests to DMA service.
// - Reset clears every DMA select bit, giving software servicing.
// - Trigger bit 6 picks rising edge (1) or level (0) for external 0.
// - Level mode bypasses the latch; pending follows the request input.
// - Switching edge to level clears the latched external 0 request.
// - Switching level to edge leaves the request flag set.
// - Receive request cleared only by reset or receive buffer read.
// - Request latched on source request; cleared on reset or vector read.
// - Writing vector/8 to the clear location clears that channel.
// - Reading two status bytes returns pending states (external 0 pin in level mode), 1 is pending.
`timescale 1ns/1ns
module iedsel_ctrl
    import iedsel_pkg::*;
#(
    parameter int CHANNELS = IEDSEL_CHANNELS
)
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic [IEDSEL_ADDR_W-1:0] bus_addr,
    input  wire logic [7:0]               bus_wdata,
    input  wire logic                     bus_wr,
    input  wire logic                     bus_rd,
    output logic      [7:0]               bus_rdata,
    input  wire logic [CHANNELS-1:0]      src_req,
    input  wire logic                     ack_valid,
    input  wire logic [IEDSEL_CH_IDX_W-1:0] ack_channel,
    input  wire logic                     rx_buffer_read,
    output logic      [CHANNELS-1:0]      cpu_irq,
    output logic      [CHANNELS-1:0]      dma_route,
    output logic      [CHANNELS-1:0]      sw_route
);
    ////////////////////////////////////////////////////////////////////////
    logic [CHANNELS-1:0] irq_enable_q;
    logic [CHANNELS-1:0] dma_select_q;
    logic [7:0]          external_trigger_control_q;
    logic [CHANNELS-1:0] pending;
    logic [CHANNELS-1:0] set_vec;
    logic [CHANNELS-1:0] clr_vec;
    logic [CHANNELS-1:0] src_req_q;
    logic [7:0]          rdata_q;
    logic                edge_mode;
    logic                to_level;

    function automatic logic hit(input logic [IEDSEL_ADDR_W-1:0] a,
                                 input logic [IEDSEL_ADDR_W-1:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    assign edge_mode = external_trigger_control_q[IEDSEL_EDGE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // enable byte writes
    // software masks first; no hardware guard
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_q <= '0;
        end else if (bus_wr) begin
            if (hit(bus_addr, IEDSEL_IEN_LO_ADDR)) begin
                irq_enable_q[7:0] <= bus_wdata;
            end
            if (hit(bus_addr, IEDSEL_IEN_HI_ADDR)) begin
                irq_enable_q[CHANNELS-1:8] <= bus_wdata[CHANNELS-9:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_select_q <= '0;
        end else if (bus_wr) begin
            if (hit(bus_addr, IEDSEL_DMA_LO_ADDR)) begin
                dma_select_q[7:0] <= bus_wdata;
            end
            if (hit(bus_addr, IEDSEL_DMA_HI_ADDR)) begin
                dma_select_q[CHANNELS-1:8] <= bus_wdata[CHANNELS-9:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            external_trigger_control_q <= IEDSEL_RESET_BYTE;
        end else if (bus_wr && hit(bus_addr, IEDSEL_EXT_TRIG_ADDR)) begin
            external_trigger_control_q <= bus_wdata & IEDSEL_EXT_TRIG_MASK;
        end
    end

    // Mode change edge to level
    assign to_level = bus_wr && hit(bus_addr, IEDSEL_EXT_TRIG_ADDR)
                      && edge_mode && !bus_wdata[IEDSEL_EDGE_BIT];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_req_q <= '0;
        end else begin
            src_req_q <= src_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        set_vec = '0;
        clr_vec = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            set_vec[i] = src_req[i];
            if (ack_valid && ack_channel == IEDSEL_CH_IDX_W'(i)) begin
                clr_vec[i] = 1'b1;
            end
            if (bus_wr && hit(bus_addr, IEDSEL_REQ_LO_ADDR)
                && bus_wdata == 8'(i)) begin
                clr_vec[i] = 1'b1;
            end
        end
        // rising edge detect in edge mode
        set_vec[IEDSEL_EXT0_CH] = edge_mode && src_req[IEDSEL_EXT0_CH]
                                  && !src_req_q[IEDSEL_EXT0_CH];
        if (!edge_mode && src_req[IEDSEL_EXT0_CH]) begin
            set_vec[IEDSEL_EXT0_CH] = 1'b1;
        end
        // auto clear on edge to level
        if (to_level) begin
            clr_vec[IEDSEL_EXT0_CH] = 1'b1;
        end
        // receive cleared only by buffer read
        clr_vec[IEDSEL_RX_CH] = rx_buffer_read;
    end

    for (genvar g = 0; g < CHANNELS; g++) begin : g_latch
        iedsel_req_latch u_latch (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .set_req  (set_vec[g]),
            .clr_req  (clr_vec[g]),
            .bypass   ((g == IEDSEL_EXT0_CH) && !edge_mode),
            .level_in (src_req[g]),
            .pending  (pending[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // masked requests held then forwarded
    assign cpu_irq   = pending & irq_enable_q;
    assign dma_route = cpu_irq & dma_select_q;
    assign sw_route  = cpu_irq & ~dma_select_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= IEDSEL_RESET_BYTE;
        end else if (bus_rd) begin
            case (bus_addr)
                IEDSEL_REQ_LO_ADDR:   rdata_q <= pending[7:0];
                IEDSEL_REQ_HI_ADDR:   rdata_q <= 8'(pending[CHANNELS-1:8]);
                IEDSEL_IEN_LO_ADDR:   rdata_q <= irq_enable_q[7:0];
                IEDSEL_IEN_HI_ADDR:   rdata_q <= 8'(irq_enable_q[CHANNELS-1:8]);
                IEDSEL_DMA_LO_ADDR:   rdata_q <= dma_select_q[7:0];
                IEDSEL_DMA_HI_ADDR:   rdata_q <= 8'(dma_select_q[CHANNELS-1:8]);
                IEDSEL_EXT_TRIG_ADDR: rdata_q <= external_trigger_control_q;
                default:              rdata_q <= IEDSEL_RESET_BYTE;
            endcase
        end else begin
            rdata_q <= IEDSEL_RESET_BYTE;
        end
    end

    assign bus_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    sequence s_ext0_edge;
        edge_mode && src_req[IEDSEL_EXT0_CH] && !src_req_q[IEDSEL_EXT0_CH];
    endsequence

    sequence s_to_level;
        to_level && !src_req[IEDSEL_EXT0_CH];
    endsequence

    sequence s_level_req;
        !edge_mode && src_req[IEDSEL_EXT0_CH];
    endsequence

    a_enable_gates_irq: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !irq_enable_q[0] |-> !cpu_irq[0])
        else $error("irq forwarded while disabled");

    a_enable_write_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_wr && hit(bus_addr, IEDSEL_IEN_LO_ADDR)
        |=> irq_enable_q[7:0] == $past(bus_wdata))
        else $error("enable low byte not written");

    a_dma_routing: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cpu_irq[5] && dma_select_q[5] |-> dma_route[5] && !sw_route[5])
        else $error("dma channel not routed to dma");

    a_level_bypass: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !edge_mode |-> pending[IEDSEL_EXT0_CH] == src_req[IEDSEL_EXT0_CH])
        else $error("level mode pending does not follow input");

    a_edge_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_ext0_edge ##1 edge_mode |-> pending[IEDSEL_EXT0_CH])
        else $error("rising edge not latched");

    a_auto_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_to_level |=> !edge_mode
                       && !g_latch[IEDSEL_EXT0_CH].u_latch.latch_q)
        else $error("edge to level not cleared");

    a_auto_clear_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        to_level |=> !g_latch[IEDSEL_EXT0_CH].u_latch.latch_q
                     || $past(src_req[IEDSEL_EXT0_CH]))
        else $error("latched external request survived mode change");

    a_rx_sw_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pending[IEDSEL_RX_CH] && !rx_buffer_read |=> pending[IEDSEL_RX_CH])
        else $error("receive request cleared without buffer read");

    a_sw_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_wr && hit(bus_addr, IEDSEL_REQ_LO_ADDR) && bus_wdata == 8'h05
        && !src_req[5] |=> !pending[5])
        else $error("clear by vector failed");

    a_status_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_rd && hit(bus_addr, IEDSEL_REQ_LO_ADDR)
        |=> bus_rdata == $past(pending[7:0]))
        else $error("status byte mismatch");

    a_masked_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pending[5] && !irq_enable_q[5] && !clr_vec[5] |=> pending[5])
        else $error("masked request lost");

    ////////////////////////////////////////////////////////////////////////
    // Reset values, checked while reset is held
    a_enable_reset: assert property (
        @(posedge sys_clk)
        !rst_n |-> irq_enable_q == '0)
        else $error("enable flags not cleared by reset");

    a_dma_reset: assert property (
        @(posedge sys_clk)
        !rst_n |-> dma_select_q == '0)
        else $error("dma select flags not cleared by reset");

    // Register writes land on the next edge
    a_enable_write_high: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_wr && hit(bus_addr, IEDSEL_IEN_HI_ADDR)
        |=> irq_enable_q[CHANNELS-1:8] == $past(bus_wdata[CHANNELS-9:0]))
        else $error("enable high byte not written");

    a_dma_write_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_wr && hit(bus_addr, IEDSEL_DMA_LO_ADDR)
        |=> dma_select_q[7:0] == $past(bus_wdata))
        else $error("dma select low byte not written");

    a_dma_write_high: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_wr && hit(bus_addr, IEDSEL_DMA_HI_ADDR)
        |=> dma_select_q[CHANNELS-1:8] == $past(bus_wdata[CHANNELS-9:0]))
        else $error("dma select high byte not written");

    // Forwarding and routing
    a_irq_forward: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        pending[5] && irq_enable_q[5] |-> cpu_irq[5])
        else $error("enabled pending request not forwarded");

    a_gates_high: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !irq_enable_q[IEDSEL_RX_CH] |-> !cpu_irq[IEDSEL_RX_CH])
        else $error("receive request forwarded while disabled");

    a_route_split: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cpu_irq[5] && !dma_select_q[5] |-> sw_route[5] && !dma_route[5])
        else $error("software channel not routed to software");

    // Request latch set and clear
    a_req_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        src_req[7] |=> pending[7])
        else $error("source request not latched");

    a_vector_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ack_valid && ack_channel == 5'h07 && !src_req[7] |=> !pending[7])
        else $error("vector read did not clear request");

    a_sw_clear_high: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_wr && hit(bus_addr, IEDSEL_REQ_LO_ADDR) && bus_wdata == 8'h09
        && !src_req[9] |=> !pending[9])
        else $error("clear by vector failed on high byte channel");

    a_rx_read_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rx_buffer_read && !src_req[IEDSEL_RX_CH] |=> !pending[IEDSEL_RX_CH])
        else $error("receive buffer read did not clear request");

    // External 0 trigger modes
    a_ext_edge_only: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        edge_mode && !src_req[IEDSEL_EXT0_CH] && !pending[IEDSEL_EXT0_CH]
        |=> !edge_mode || !pending[IEDSEL_EXT0_CH])
        else $error("edge mode latched without a rising edge");

    a_level_keep: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_level_req ##1 edge_mode |-> pending[IEDSEL_EXT0_CH])
        else $error("level request lost on switch to edge");

    // Read port
    a_status_high: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bus_rd && hit(bus_addr, IEDSEL_REQ_HI_ADDR)
        |=> bus_rdata == 8'($past(pending[CHANNELS-1:8])))
        else $error("high status byte mismatch");

    a_rdata_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !bus_rd |=> bus_rdata == IEDSEL_RESET_BYTE)
        else $error("read data not idle outside a read");
endmodule : iedsel_ctrl

// file: testbench/iedsel_src_model.sv
// Partner model: peripherals raising requests and CPU accepting them
`timescale 1ns/1ns
module iedsel_src_model
    import iedsel_pkg::*;
(
    input  wire logic                       sys_clk,
    output logic      [IEDSEL_CHANNELS-1:0] src_req,
    output logic                            ack_valid,
    output logic      [IEDSEL_CH_IDX_W-1:0] ack_channel,
    output logic                            rx_buffer_read
);
    initial begin
        src_req        = '0;
        ack_valid      = 1'b0;
        ack_channel    = '0;
        rx_buffer_read = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle request from a peripheral
    task automatic pulse_req(input int ch);
        @(posedge sys_clk);
        src_req[ch] <= 1'b1;
        @(posedge sys_clk);
        src_req[ch] <= 1'b0;
    endtask : pulse_req

    // Held request line, as an external pin would give
    task automatic set_level(input int ch, input logic v);
        @(posedge sys_clk);
        src_req[ch] <= v;
    endtask : set_level

    // index truncated to IEDSEL_CH_IDX_W bits here
    // Vector read by the core; index garbled once released
    task automatic accept(input int ch);
        @(posedge sys_clk);
        ack_valid   <= 1'b1;
        ack_channel <= ch[IEDSEL_CH_IDX_W-1:0];
        @(posedge sys_clk);
        ack_valid   <= 1'b0;
        ack_channel <= ~ch[IEDSEL_CH_IDX_W-1:0];
    endtask : accept

    // Receive buffer read by software
    task automatic read_rx;
        @(posedge sys_clk);
        rx_buffer_read <= 1'b1;
        @(posedge sys_clk);
        rx_buffer_read <= 1'b0;
    endtask : read_rx
endmodule : iedsel_src_model

// file: testbench/irq_enable_and_dma_select_tb_top.sv
// Testbench: register access, request latches and external trigger modes
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module irq_enable_and_dma_select_tb_top
    import iedsel_pkg::*;
;
    logic                       sys_clk;
    logic                       rst_n;
    logic [IEDSEL_ADDR_W-1:0]   bus_addr;
    logic [7:0]                 bus_wdata;
    logic                       bus_wr;
    logic                       bus_rd;
    logic [7:0]                 bus_rdata;
    logic [IEDSEL_CHANNELS-1:0] src_req;
    logic                       ack_valid;
    logic [IEDSEL_CH_IDX_W-1:0] ack_channel;
    logic                       rx_buffer_read;
    logic [IEDSEL_CHANNELS-1:0] cpu_irq;
    logic [IEDSEL_CHANNELS-1:0] dma_route;
    logic [IEDSEL_CHANNELS-1:0] sw_route;
    int                         err_total;
    int                         num_checks;
    logic [15:0]                reg_tab [4];

    iedsel_ctrl #(.CHANNELS(IEDSEL_CHANNELS)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .src_req(src_req), .ack_valid(ack_valid),
        .ack_channel(ack_channel), .rx_buffer_read(rx_buffer_read),
        .cpu_irq(cpu_irq), .dma_route(dma_route), .sw_route(sw_route)
    );

    iedsel_src_model u_src (
        .sys_clk(sys_clk), .src_req(src_req), .ack_valid(ack_valid),
        .ack_channel(ack_channel), .rx_buffer_read(rx_buffer_read)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge sys_clk);
        bus_wr    <= 1'b0;
        bus_wdata <= ~d;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge sys_clk);
        bus_rd   <= 1'b0;
        bus_addr <= ~a;
        #1;
        `CHK(bus_rdata, e)
    endtask : rd_chk

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_total  = 0;
        num_checks = 0;
        rst_n      = 1'b0;
        bus_addr   = '0;
        bus_wdata  = '0;
        bus_wr     = 1'b0;
        bus_rd     = 1'b0;
        reg_tab    = '{IEDSEL_DMA_LO_ADDR, IEDSEL_DMA_HI_ADDR,
                       IEDSEL_IEN_LO_ADDR, IEDSEL_IEN_HI_ADDR};
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values, status and trigger all clear
        foreach (reg_tab[i]) rd_chk(reg_tab[i], 8'h00);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h00);
        rd_chk(IEDSEL_REQ_HI_ADDR, 8'h00);
        rd_chk(IEDSEL_EXT_TRIG_ADDR, 8'h00);
        rd_chk(16'h1234, 8'h00);
        foreach (reg_tab[i]) wr(reg_tab[i], 8'h5a ^ 8'(i));
        foreach (reg_tab[i]) rd_chk(reg_tab[i], 8'h5a ^ 8'(i));
        foreach (reg_tab[i]) wr(reg_tab[i], 8'h00);
        // Masked request stays pending, then forwarded
        u_src.pulse_req(5);
        #1;
        `CHK(cpu_irq, 16'h0000)
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h20);
        wr(IEDSEL_IEN_LO_ADDR, 8'h20);
        `CHK(cpu_irq, 16'h0020)
        `CHK(sw_route, 16'h0020)
        wr(IEDSEL_DMA_LO_ADDR, 8'h20);
        `CHK(dma_route, 16'h0020)
        `CHK(sw_route, 16'h0000)
        wr(IEDSEL_REQ_LO_ADDR, 8'h05);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h00);
        // High byte channel cleared through the low location
        u_src.pulse_req(9);
        rd_chk(IEDSEL_REQ_HI_ADDR, 8'h02);
        wr(IEDSEL_REQ_LO_ADDR, 8'h09);
        rd_chk(IEDSEL_REQ_HI_ADDR, 8'h00);
        // Vector read clears the latch
        u_src.pulse_req(7);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h80);
        u_src.accept(7);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h00);
        // Serial receive ignores software clear
        u_src.pulse_req(IEDSEL_RX_CH);
        wr(IEDSEL_REQ_LO_ADDR, 8'h0c);
        rd_chk(IEDSEL_REQ_HI_ADDR, 8'h10);
        u_src.read_rx();
        rd_chk(IEDSEL_REQ_HI_ADDR, 8'h00);
        // External 0 in level mode follows the pin
        wr(IEDSEL_IEN_LO_ADDR, 8'h08);
        u_src.set_level(IEDSEL_EXT0_CH, 1'b1);
        #1;
        `CHK(cpu_irq, 16'h0008)
        u_src.set_level(IEDSEL_EXT0_CH, 1'b0);
        #1;
        `CHK(cpu_irq, 16'h0000)
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h00);
        // Level to edge keeps the flag, cleared by code 03
        u_src.set_level(IEDSEL_EXT0_CH, 1'b1);
        wr(IEDSEL_EXT_TRIG_ADDR, IEDSEL_EXT_TRIG_MASK);
        u_src.set_level(IEDSEL_EXT0_CH, 1'b0);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h08);
        rd_chk(IEDSEL_EXT_TRIG_ADDR, 8'h40);
        wr(IEDSEL_REQ_LO_ADDR, 8'h03);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h00);
        // Edge mode latches a rising edge
        u_src.pulse_req(IEDSEL_EXT0_CH);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h08);
        // Edge to level drops the latched request
        wr(IEDSEL_EXT_TRIG_ADDR, 8'h00);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h00);
        // Back in edge mode the latch must still be empty
        wr(IEDSEL_EXT_TRIG_ADDR, IEDSEL_EXT_TRIG_MASK);
        rd_chk(IEDSEL_REQ_LO_ADDR, 8'h00);
        // Mid-run reset clears every flag again
        foreach (reg_tab[i]) wr(reg_tab[i], 8'hff);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (reg_tab[i]) rd_chk(reg_tab[i], 8'h00);
        rd_chk(IEDSEL_EXT_TRIG_ADDR, 8'h00);
        `CHK(cpu_irq, 16'h0000)
        wrap_up();
    end
endmodule : irq_enable_and_dma_select_tb_top
